/* pcw_chk.sv */
`include "pcw_defines.vh"
module pcw_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        gen_ext_in,
  input wire logic        fault_in,
  input wire logic        pwm_out,
  input wire logic        output_a,
  input wire logic        output_b,
  input wire logic        output_c,
  input wire logic        output_d
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       on_q, pol_q, en_q;
  logic [7:0] dh_q;
  logic [1:0] dl_q;
  logic [2:0] md_q, off_q, flt_q;
  wire        wr_c  = psel & penable & pready & pwrite;
  wire        rd_c  = pready & ~pwrite;
  wire        quiet = ~(output_a | output_b | output_c | output_d);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // shadows follow committed writes only, so refused or pending requests never leak in
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {on_q, pol_q, en_q, dl_q, md_q, off_q, flt_q} <= '0;
      dh_q <= `PCW_R_BYTE;
    end else begin
      if (wr_c && paddr == `PCW_A_PWM_CTL) begin
        on_q  <= pwdata[`PCW_B_PWM_ON];
        pol_q <= pwdata[`PCW_B_PWM_POL];
      end
      if (wr_c && paddr == `PCW_A_DUTY_HI) dh_q <= pwdata[7:0];
      if (wr_c && paddr == `PCW_A_DUTY_LO) dl_q <= pwdata[7:6];
      if (wr_c && paddr == `PCW_A_WF_CTL0) begin
        en_q <= pwdata[`PCW_B_WF_EN];
        md_q <= pwdata[2:0];
      end
      // saturating counts leave room for the input and output pipeline
      off_q <= en_q ? 3'h0 : off_q + {2'h0, off_q != 3'h7};
      flt_q <= fault_in ? flt_q + {2'h0, flt_q != 3'h7} : 3'h0;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctl_rd;
    rd_c && paddr == `PCW_A_PWM_CTL;
  endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("no answer after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("answer held too long");
  a_bad_addr: assert property (pready && paddr > `PCW_A_SHUT |-> pslverr)
    else $error("unmapped address accepted");
  a_bad_rdata: assert property (rd_c && pslverr |-> prdata == 32'h0)
    else $error("refused read gave data");
  a_level_read: assert property (s_ctl_rd |-> prdata[5] == $past(pwm_out))
    else $error("level readback wrong");
  a_ctl_read: assert property (s_ctl_rd |-> prdata[7] == $past(on_q) && prdata[4] == $past(pol_q)
    && prdata[6] == 1'b0 && prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
    else $error("control readback wrong");
  a_duty_hi: assert property (rd_c && paddr == `PCW_A_DUTY_HI |-> prdata == {24'h0, $past(dh_q)})
    else $error("duty high readback wrong");
  a_duty_lo: assert property (rd_c && paddr == `PCW_A_DUTY_LO |-> prdata == {24'h0, $past(dl_q), 6'h0})
    else $error("duty low readback wrong");
  a_idle_level: assert property (!on_q && !$past(on_q) && !$past(on_q, 2) && pol_q == $past(pol_q, 2)
    |-> pwm_out == pol_q) else $error("idle level wrong");
  a_gen_off: assert property (off_q == 3'h7 |-> quiet) else $error("disabled generator drives");
  a_fault_quiet: assert property (flt_q == 3'h7 && md_q >= `PCW_M_FB_FWD |-> quiet)
    else $error("fault did not shut down");
endmodule // pcw_chk
bind pcw_top pcw_chk pcw_chk_inst (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .gen_ext_in, .fault_in, .pwm_out, .output_a, .output_b, .output_c,
  .output_d);

/* pcw_defines.vh */
`ifndef PCW_DEFINES_VH
`define PCW_DEFINES_VH
// register byte addresses
`define PCW_A_PWM_CTL   8'h00
`define PCW_A_DUTY_HI   8'h04
`define PCW_A_DUTY_LO   8'h08
`define PCW_A_PERIOD    8'h0C
`define PCW_A_TIMER     8'h10
`define PCW_A_WF_CTL0   8'h14
`define PCW_A_WF_CTL1   8'h18
`define PCW_A_DB_RISE   8'h1C
`define PCW_A_DB_FALL   8'h20
`define PCW_A_STEER     8'h24
`define PCW_A_SHUT      8'h28
// modulator control fields
`define PCW_B_PWM_ON    7
`define PCW_B_PWM_LVL   5
`define PCW_B_PWM_POL   4
`define PCW_B_DUTY_LO   7
// waveform control first fields
`define PCW_B_WF_EN     7
`define PCW_B_WF_LD     6
`define PCW_B_WF_SRC    3
// shutdown fields
`define PCW_B_SHUT      0
`define PCW_B_RESTART   1
// generator modes
`define PCW_M_STEER_ASY 3'h0
`define PCW_M_STEER_SYN 3'h1
`define PCW_M_FB_FWD    3'h2
`define PCW_M_FB_REV    3'h3
`define PCW_M_HALF      3'h4
`define PCW_M_PUSHPULL  3'h5
// reset values
`define PCW_R_PERIOD    8'hFF
`define PCW_R_BYTE      8'h00
`endif

/* pcw_gate_drv.sv */
module pcw_gate_drv (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       trip,
  input  wire logic       output_a,
  input  wire logic       output_b,
  input  wire logic       output_c,
  input  wire logic       output_d,
  output logic            fault_in,
  output logic [7:0]      shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // a sensed fault reaches the block one clock late, as a real driver stage would
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fault_in  <= 1'b0;
      shoot_cnt <= 8'h00;
    end else begin
      fault_in <= trip;
      if ((output_a & output_b) | (output_c & output_d)) shoot_cnt <= shoot_cnt + 8'h01;
    end
  end
endmodule // pcw_gate_drv

/* pcw_tb_top.sv */
`include "pcw_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("Error %0t got %0h exp %0h", $time, g, e); end end
module pcw_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        gen_ext_in = 1'b0, trip = 1'b0, se, pa, pb;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  wire  [31:0] prdata;
  wire  [7:0]  shoot_cnt;
  wire         pready, pslverr, fault_in, pwm_out, output_a, output_b, output_c, output_d;
  int          miscompares = 0, cmp_count = 0, ca, cb, cc, cd, cp, ov, cpy, ra, first;
  always #5 clk_sys = ~clk_sys;
  pcw_top pcw_top_inst (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gen_ext_in, .fault_in, .pwm_out, .output_a, .output_b, .output_c, .output_d);
  pcw_gate_drv pcw_gate_drv_inst (.clk_sys, .reset, .trip, .output_a, .output_b, .output_c,
    .output_d, .fault_in, .shoot_cnt);
  task automatic give_verdict;
    $display("Compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      give_verdict;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic clr;
    {ca, cb, cc, cd, cp, ov, cpy, ra, first} = '0;
    pa = output_a;
    pb = output_b;
  endtask
  // counts are taken mid-cycle, clear of the edge that updates the outputs
  task automatic watch(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      `CHK($isunknown({pwm_out, output_a, output_b, output_c, output_d}), 1'b0)
      ca  += int'(output_a);
      cb  += int'(output_b);
      cc  += int'(output_c);
      cd  += int'(output_d);
      cp  += int'(pwm_out);
      ov  += int'(output_a & output_b);
      cpy += int'(output_c !== output_a || output_d !== output_b);
      ra  += int'(output_a & ~pa);
      if (first == 0 && output_a === 1'b1 && pa === 1'b0) first = 1;
      if (first == 0 && output_b === 1'b1 && pb === 1'b0) first = 2;
      pa = output_a;
      pb = output_b;
    end
  endtask
  task automatic pulse(input int h, input int l, input int k);
    repeat (k) begin
      @(posedge clk_sys);
      gen_ext_in <= 1'b1;
      watch(h);
      @(posedge clk_sys);
      gen_ext_in <= 1'b0;
      watch(l);
    end
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h30, 32'h0);
    `CHK({se, rd}, {1'b1, 32'h0})
    apb(1'b0, `PCW_A_PWM_CTL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, `PCW_A_PERIOD, 32'h0);
    `CHK(rd, {24'h0, `PCW_R_PERIOD})
    wr(`PCW_A_DUTY_HI, 8'hA5);
    wr(`PCW_A_DUTY_LO, 8'hFF);
    apb(1'b0, `PCW_A_DUTY_HI, 32'h0);
    `CHK(rd, 32'hA5)
    apb(1'b0, `PCW_A_DUTY_LO, 32'h0);
    `CHK(rd, 32'hC0)
    wr(`PCW_A_PWM_CTL, 8'h5F);
    apb(1'b0, `PCW_A_PWM_CTL, 32'h0);
    `CHK(rd, 32'h30)
    $display("t_regs done");
  endtask
  task automatic t_pwm;
    wr(`PCW_A_PERIOD, 8'h00);
    wr(`PCW_A_DUTY_HI, 8'h00);
    wr(`PCW_A_DUTY_LO, 8'h40);
    wr(`PCW_A_PWM_CTL, 8'h80);
    // a period below the running count waits for the base to roll over
    watch(1030);
    clr;
    watch(40);
    `CHK(cp, 10)
    apb(1'b0, `PCW_A_TIMER, 32'h0);
    `CHK(rd, 32'h0)
    wr(`PCW_A_PWM_CTL, 8'h90);
    watch(12);
    clr;
    watch(40);
    `CHK(cp, 30)
    wr(`PCW_A_PWM_CTL, 8'h10);
    watch(4);
    clr;
    watch(20);
    `CHK(cp, 20)
    $display("t_pwm done");
  endtask
  task automatic t_gen;
    wr(`PCW_A_WF_CTL1, 8'h0F);
    wr(`PCW_A_DB_RISE, 8'h03);
    wr(`PCW_A_DB_FALL, 8'h03);
    wr(`PCW_A_WF_CTL0, 8'h8C);
    clr;
    pulse(12, 12, 3);
    `CHK(ov, 0)
    `CHK(cpy, 0)
    `CHK(ca inside {[24:30]}, 1'b1)
    wr(`PCW_A_WF_CTL0, 8'h0D);
    wr(`PCW_A_WF_CTL0, 8'h8D);
    clr;
    pulse(4, 4, 3);
    `CHK({ra, first, cpy}, {32'd2, 32'd1, 32'd0})
    wr(`PCW_A_WF_CTL0, 8'h0D);
    wr(`PCW_A_WF_CTL0, 8'h8D);
    clr;
    pulse(4, 4, 1);
    `CHK(first, 1)
    $display("t_gen done");
  endtask
  task automatic t_bridge;
    wr(`PCW_A_WF_CTL0, 8'h0A);
    wr(`PCW_A_WF_CTL0, 8'h8A);
    clr;
    pulse(6, 6, 3);
    `CHK({output_a, output_b, output_c, cb, cd > 0}, {3'b100, 32'd0, 1'b1})
    wr(`PCW_A_WF_CTL0, 8'h8B);
    clr;
    pulse(6, 6, 3);
    `CHK({output_a, output_c, output_d, cd}, {3'b010, 32'd0})
    `CHK(cb inside {[14:16]}, 1'b1)
    $display("t_bridge done");
  endtask
  task automatic t_steer;
    wr(`PCW_A_WF_CTL0, 8'h08);
    wr(`PCW_A_STEER, 8'h01);
    wr(`PCW_A_WF_CTL0, 8'h88);
    @(posedge clk_sys);
    gen_ext_in <= 1'b1;
    watch(6);
    `CHK({output_a, output_b}, 2'b10)
    wr(`PCW_A_STEER, 8'h00);
    watch(3);
    `CHK(output_a, 1'b0)
    wr(`PCW_A_STEER, 8'h01);
    wr(`PCW_A_WF_CTL0, 8'h89);
    wr(`PCW_A_STEER, 8'h00);
    watch(6);
    `CHK(output_a, 1'b1)
    pulse(0, 4, 1);
    pulse(6, 0, 1);
    `CHK(output_a, 1'b0)
    $display("t_steer done");
  endtask
  task automatic t_fault;
    pulse(0, 4, 1);
    wr(`PCW_A_WF_CTL0, 8'h0C);
    wr(`PCW_A_WF_CTL0, 8'h8C);
    @(posedge clk_sys);
    trip <= 1'b1;
    watch(6);
    clr;
    pulse(6, 6, 2);
    `CHK(ca + cb + cc + cd, 0)
    @(posedge clk_sys);
    trip <= 1'b0;
    watch(4);
    wr(`PCW_A_SHUT, 8'h00);
    clr;
    pulse(6, 6, 2);
    `CHK(ca > 0, 1'b1)
    `CHK(shoot_cnt, 8'h00)
    $display("t_fault done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs;
    t_pwm;
    t_gen;
    t_bridge;
    t_steer;
    t_fault;
    give_verdict;
  end
endmodule // pcw_tb_top

/* pcw_top.v */
// Contract
// - modulator runs while control bit 7 is one, idle when zero
// - control bit 5 reads back the present modulator output level
// - control bit 4 set makes modulator output active low
// - duty high holds duty bits 9..2, duty low bits 7..6 hold 1..0
// - generator offers six modes from the first control mode field
// - half bridge drives true and inverted input with dead band
// - half bridge outputs c and d follow a and b, own polarity
// - push pull sends successive input pulses to a and b in turn
// - push pull sequencer resets when disabled or shut down
// - input pulses advance sequencer, first pulse goes to a
// - push pull outputs c and d copy a and b, own polarity
// - forward full bridge: a active, b c inactive, d modulated
// - reverse full bridge: c active, a d inactive, b modulated
// - full bridge dead band only on direction change
// - mode bit 0 flips bridge direction while running
// - every mode obeys auto-shutdown on a fault
// - separate six bit rising and falling dead band timers
// - steering applies immediately or at next rising input
// - mode 000 steers at once, 001 at next input rise
// - dead band counts clock periods from zero to register value
// - disabled modulator output sits at polarity default level
// - duty writes buffered, take effect at period match
`include "pcw_defines.vh"
module pcw_top #(
  parameter DB_W = 6
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        gen_ext_in,
  input  wire        fault_in,
  output reg         pwm_out,
  output reg         output_a,
  output reg         output_b,
  output reg         output_c,
  output reg         output_d
);
  reg            pwm_on_q;
  reg            pwm_pol_q;
  reg  [7:0]     duty_hi_q;
  reg  [1:0]     duty_lo_q;
  reg  [9:0]     duty_lat_q;
  reg  [7:0]     period_q;
  reg  [9:0]     tbase_q;
  reg            wf_en_q;
  reg            ld_q;
  reg            src_q;
  reg  [2:0]     mode_q;
  reg  [3:0]     pol_q;
  reg  [DB_W-1:0] dbr_q;
  reg  [DB_W-1:0] dbf_q;
  reg  [DB_W-1:0] dbr_act_q;
  reg  [DB_W-1:0] dbf_act_q;
  reg  [DB_W-1:0] rcnt_q;
  reg  [DB_W-1:0] fcnt_q;
  reg            rrun_q;
  reg            frun_q;
  reg  [3:0]     str_q;
  reg  [3:0]     lvl_q;
  reg  [3:0]     str_act_q;
  reg            shut_q;
  reg            restart_q;
  reg            in_q;
  reg            in_p_q;
  reg            dir_q;
  reg            nxt_q;
  reg            sel_q;
  reg  [31:0]    rdata;
  reg            rmiss;
  reg  [3:0]     act;
  reg  [3:0]     outs;
  wire           wr;
  wire           rise;
  wire           fall;
  wire           is_half;
  wire           is_fb;
  wire           is_pp;
  wire           is_steer;
  wire           dir_n;
  wire           dir_chg;
  wire           sel_n;
  wire           r_start;
  wire           f_start;
  wire [3:0]     str_n;
  wire           wrap;
  wire [9:0]     duty_buf;
  wire [3:0]     pol_act;
  wire [3:0]     steer_mix;
  wire           shut_wr;
  wire           shut_set;
  wire           ld_wr;

  // writes land at the access edge only, so no setup-phase side effects
  assign wr       = psel & penable & pready & pwrite;
  assign rise     = in_q & ~in_p_q;
  assign fall     = ~in_q & in_p_q;
  assign is_half  = (mode_q == `PCW_M_HALF);
  assign is_pp    = (mode_q == `PCW_M_PUSHPULL);
  assign is_fb    = (mode_q[2:1] == 2'b01);
  assign is_steer = (mode_q[2:1] == 2'b00);
  assign dir_n    = (is_fb & rise) ? mode_q[0] : dir_q;
  assign dir_chg  = is_fb & rise & (mode_q[0] != dir_q);
  assign sel_n    = rise ? nxt_q : sel_q;
  // zero dead band means no counting at all
  assign r_start  = ((is_half & rise) | (dir_chg & mode_q[0])) &
                    (dbr_act_q != {DB_W{1'b0}});
  assign f_start  = ((is_half & fall) | (dir_chg & ~mode_q[0])) &
                    (dbf_act_q != {DB_W{1'b0}});
  assign str_n    = (mode_q == `PCW_M_STEER_SYN & ~rise) ?
                    str_act_q : str_q;
  // the base clears only on an exact match: a period written below the running
  // count lets the base run on to its ten-bit roll-over first
  assign wrap     = (tbase_q[9:2] == period_q) & (tbase_q[1:0] == 2'h3);

  assign duty_buf  = {duty_hi_q, duty_lo_q};
  // polarity only shapes modulated drive; fixed steering levels bypass it
  assign pol_act   = act ^ ~pol_q;
  assign steer_mix = (str_n & pol_act) | (~str_n & lvl_q);
  // shutdown requests and clears are decoded once for the state process
  assign shut_wr   = wr & (paddr == `PCW_A_SHUT);
  assign shut_set  = fault_in | (shut_wr & pwdata[`PCW_B_SHUT]);
  assign ld_wr     = wr & (paddr == `PCW_A_WF_CTL0) & pwdata[`PCW_B_WF_LD];

  always @* begin
    rmiss = 1'b0;
    rdata = 32'h0000_0000;
    case (paddr)
      `PCW_A_PWM_CTL: begin
        rdata[`PCW_B_PWM_ON]  = pwm_on_q;
        rdata[`PCW_B_PWM_LVL] = pwm_out;
        rdata[`PCW_B_PWM_POL] = pwm_pol_q;
      end
      `PCW_A_DUTY_HI: rdata[7:0] = duty_hi_q;
      `PCW_A_DUTY_LO: rdata[7:6] = duty_lo_q;
      `PCW_A_PERIOD:  rdata[7:0] = period_q;
      `PCW_A_TIMER:   rdata[7:0] = tbase_q[9:2];
      `PCW_A_WF_CTL0: rdata[7:0] = {wf_en_q, ld_q, 2'b00, src_q, mode_q};
      `PCW_A_WF_CTL1: rdata[3:0] = pol_q;
      `PCW_A_DB_RISE: rdata[DB_W-1:0] = dbr_q;
      `PCW_A_DB_FALL: rdata[DB_W-1:0] = dbf_q;
      `PCW_A_STEER:   rdata[7:0] = {lvl_q, str_q};
      `PCW_A_SHUT:    rdata[1:0] = {restart_q, shut_q};
      // unmapped offsets refuse the access and read as zero
      default:        rmiss = 1'b1;
    endcase
  end

  // one wait-free access: data captured during setup, ready in access
  // pready is a one-cycle pulse, so a setup that follows at once is still seen
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & rmiss;
      if (psel & ~penable & ~pready & ~pwrite) begin
        prdata <= rdata;
      end
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwm_on_q  <= 1'b0;
      pwm_pol_q <= 1'b0;
      duty_hi_q <= `PCW_R_BYTE;
      duty_lo_q <= 2'h0;
      period_q  <= `PCW_R_PERIOD;
      wf_en_q   <= 1'b0;
      src_q     <= 1'b0;
      mode_q    <= `PCW_M_STEER_ASY;
      pol_q     <= 4'h0;
      dbr_q     <= {DB_W{1'b0}};
      dbf_q     <= {DB_W{1'b0}};
      str_q     <= 4'h0;
      lvl_q     <= 4'h0;
      restart_q <= 1'b0;
    end else if (wr & ~pslverr) begin
      case (paddr)
        `PCW_A_PWM_CTL: begin
          pwm_on_q  <= pwdata[`PCW_B_PWM_ON];
          pwm_pol_q <= pwdata[`PCW_B_PWM_POL];
        end
        `PCW_A_DUTY_HI: duty_hi_q <= pwdata[7:0];
        `PCW_A_DUTY_LO: duty_lo_q <= pwdata[`PCW_B_DUTY_LO -: 2];
        `PCW_A_PERIOD:  period_q  <= pwdata[7:0];
        `PCW_A_WF_CTL0: begin
          wf_en_q <= pwdata[`PCW_B_WF_EN];
          src_q   <= pwdata[`PCW_B_WF_SRC];
          mode_q  <= pwdata[2:0];
        end
        `PCW_A_WF_CTL1: pol_q <= pwdata[3:0];
        `PCW_A_DB_RISE: dbr_q <= pwdata[DB_W-1:0];
        `PCW_A_DB_FALL: dbf_q <= pwdata[DB_W-1:0];
        `PCW_A_STEER: begin
          str_q <= pwdata[3:0];
          lvl_q <= pwdata[7:4];
        end
        `PCW_A_SHUT: restart_q <= pwdata[`PCW_B_RESTART];
        default: begin
        end
      endcase
    end
  end

  // modulator time base: 8-bit count plus two low bits gives ten bits
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tbase_q    <= 10'h000;
      duty_lat_q <= 10'h000;
      pwm_out    <= 1'b0;
    end else begin
      if (wrap) begin
        tbase_q    <= 10'h000;
        duty_lat_q <= duty_buf;
      end else begin
        tbase_q <= tbase_q + 10'h001;
      end
      // duty 0 never sets the pin; duty above period keeps it high
      // polarity acts at the output flop, so a change shows within one clock
      if (pwm_on_q) begin
        pwm_out <= (tbase_q < duty_lat_q) ^ pwm_pol_q;
      end else begin
        pwm_out <= pwm_pol_q;
      end
    end
  end

  // generator input, edges and dead band buffers
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      in_q      <= 1'b0;
      in_p_q    <= 1'b0;
      ld_q      <= 1'b0;
      dbr_act_q <= {DB_W{1'b0}};
      dbf_act_q <= {DB_W{1'b0}};
    end else begin
      in_q   <= src_q ? gen_ext_in : pwm_out;
      in_p_q <= in_q;
      // a new load request beats the clearing falling edge
      ld_q <= ld_wr | (ld_q & ~(fall & wf_en_q));
      // while the generator is off the buffers follow the registers freely
      if (~wf_en_q | (ld_q & fall)) begin
        dbr_act_q <= dbr_q;
        dbf_act_q <= dbf_q;
      end
    end
  end

  // dead band counters run from zero up to the buffered value
  // the start cycle is step zero, so a value of n blanks n+1 clocks
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rcnt_q <= {DB_W{1'b0}};
      fcnt_q <= {DB_W{1'b0}};
      rrun_q <= 1'b0;
      frun_q <= 1'b0;
    end else begin
      if (r_start) begin
        rcnt_q <= {{(DB_W-1){1'b0}}, 1'b1};
        rrun_q <= 1'b1;
      end else if (rrun_q & (rcnt_q == dbr_act_q)) begin
        rrun_q <= 1'b0;
      end else if (rrun_q) begin
        rcnt_q <= rcnt_q + {{(DB_W-1){1'b0}}, 1'b1};
      end
      if (f_start) begin
        fcnt_q <= {{(DB_W-1){1'b0}}, 1'b1};
        frun_q <= 1'b1;
      end else if (frun_q & (fcnt_q == dbf_act_q)) begin
        frun_q <= 1'b0;
      end else if (frun_q) begin
        fcnt_q <= fcnt_q + {{(DB_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // direction, push-pull sequencer, steering and shutdown state
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dir_q     <= 1'b0;
      nxt_q     <= 1'b0;
      sel_q     <= 1'b0;
      str_act_q <= 4'h0;
      shut_q    <= 1'b0;
    end else begin
      // direction moves only on a rising input, so a and c switch with a pulse
      dir_q     <= dir_n;
      str_act_q <= str_n;
      // the sequencer also steps outside push-pull; only disable or shutdown resets it
      if (~wf_en_q | shut_q) begin
        nxt_q <= 1'b0;
        sel_q <= 1'b0;
      end else if (rise) begin
        sel_q <= nxt_q;
        nxt_q <= ~nxt_q;
      end
      // a fault or software request wins over any clear
      if (shut_set) begin
        shut_q <= 1'b1;
      end else if (shut_wr & ~restart_q) begin
        shut_q <= 1'b0;
      end else if (restart_q & rise) begin
        shut_q <= 1'b0;
      end
    end
  end

  // active levels before polarity
  always @* begin
    act = 4'h0;
    case (mode_q)
      `PCW_M_HALF: begin
        act[0] = in_q & ~rrun_q & ~r_start;
        act[1] = ~in_q & ~frun_q & ~f_start;
        act[3:2] = act[1:0];
      end
      `PCW_M_PUSHPULL: begin
        act[0] = in_q & ~sel_n;
        act[1] = in_q & sel_n;
        act[3:2] = act[1:0];
      end
      `PCW_M_FB_FWD, `PCW_M_FB_REV: begin
        act[0] = ~dir_n;
        act[2] = dir_n;
        act[1] = dir_n & in_q & ~rrun_q & ~r_start;
        act[3] = ~dir_n & in_q & ~frun_q & ~f_start;
      end
      // steering modes offer the input to all four pins; str_n picks which
      default: act = {4{in_q}};
    endcase
  end

  // polarity set means active high; fixed and shutdown levels ignore it
  always @* begin
    outs = 4'h0;
    if (wf_en_q) begin
      if (is_steer) begin
        outs = steer_mix;
        if (shut_q) begin
          outs = outs & ~str_n;
        end
      end else if (~shut_q) begin
        outs = pol_act;
      end
    end
  end

  // every pin leaves a flip-flop so the gate drivers never see decode glitches
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      output_a <= 1'b0;
      output_b <= 1'b0;
      output_c <= 1'b0;
      output_d <= 1'b0;
    end else begin
      output_a <= outs[0];
      output_b <= outs[1];
      output_c <= outs[2];
      output_d <= outs[3];
    end
  end
endmodule // pcw_top
